/* link_peer.sv */
// far-side synchronous peer: clocks one frame in when started
`timescale 1ns/1ns

module link_peer (
	// frame request
	input  wire logic       go,
	input  wire logic [7:0] word,
	// line drive
	output logic            clk_o,
	output logic            clk_oe,
	output logic            dat_o,
	output logic            dat_oe
);
	initial begin
		clk_o = 1'b1;
		clk_oe = 1'b0;
		dat_o = 1'b1;
		dat_oe = 1'b0;
	end

	// external clock only within a frame
	always @(posedge go) begin
		clk_oe = 1'b1;
		dat_oe = 1'b1;
		for (int i = 0; i < 8; i++) begin
			dat_o = word[i];
			clk_o = 1'b0;
			#80 clk_o = 1'b1;
			#80;
		end
		clk_oe = 1'b0;
		dat_oe = 1'b0;
	end
endmodule // link_peer

/* tb.sv */
// self-checking bench of the serial control block
`timescale 1ns/1ns
`include "usart_ctl_defines.vh"

module tb;
	localparam [7:0] RC = `RCV_SC_IDX << 2;
	localparam [7:0] TC = `XMT_SC_IDX << 2;
	localparam [7:0] IS = `IRQ_STAT_IDX << 2;
	localparam [7:0] IM = `IRQ_MASK_IDX << 2;
	logic        clk_sys, nrst, read, write, waitrequest, irq, go, tx_data_in, baud_clk_in;
	logic        rx_word_done, rx_ninth_in, rx_frame_err_in, rx_overrun_in, rx_buffer_read, tsr_empty_in;
	logic        rx_active, tx_active, rx_nine, tx_nine, tx_ninth_bit, data_in, link_clk_rise, link_clk_fall;
	logic        data_pin_i, data_pin_o, data_pin_oe, clk_pin_i, clk_pin_o, clk_pin_oe, pc_o, pc_oe, pd_o, pd_oe;
	logic [1:0]  config_mode;
	logic [7:0]  address, q, w, v, word;
	logic [7:0]  rt [4] = '{8'h00, 8'h80, 8'h80, 8'h80};
	logic [7:0]  tt [4] = '{8'h00, 8'h00, 8'h90, 8'h10};
	logic [31:0] writedata, readdata;
	int          errors, checks, n, rises, r0;

	usart_ctl i_dut (.*);
	link_peer i_peer (.go(go), .word(word), .clk_o(pc_o), .clk_oe(pc_oe), .dat_o(pd_o), .dat_oe(pd_oe));
	// released lines pulled up
	assign data_pin_i = data_pin_oe ? data_pin_o : pd_oe ? pd_o : 1'b1;
	assign clk_pin_i = clk_pin_oe ? clk_pin_o : pc_oe ? pc_o : 1'b1;

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) rises <= rises + link_clk_rise;

	////////////////////////////////////////////////////////////////
	task automatic close_out;
		if (errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		n = 0;
		address <= a;
		writedata <= {24'h0, d};
		write <= wr;
		read <= !wr;
		tick(1);
		while (waitrequest !== 1'b0) begin
			n++;
			if (n > 40) begin
				errors++;
				close_out;
			end
			tick(1);
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
		// outputs lag the register by one edge; let it settle before any check
		tick(2);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	// word done, overrun, buffer read strobes
	task automatic st(input logic [2:0] s);
		{rx_word_done, rx_overrun_in, rx_buffer_read} <= s;
		tick(1);
		{rx_word_done, rx_overrun_in, rx_buffer_read} <= 3'h0;
		tick(1);
	endtask
	function automatic logic [7:0] tc_exp(input logic [7:0] d);
		return (d & 8'hf1) | {6'h0, tsr_empty_in, 1'b0};
	endfunction
	function automatic logic [1:0] cfg_exp(input logic [7:0] r, input logic [7:0] t);
		if (!r[`RC_PORT_EN])
			return `CFG_OFF;
		if (!t[`TC_SYNC_MODE])
			return `CFG_ASYNC;
		return t[`TC_CLK_SRC] ? `CFG_SYNC_MASTER : `CFG_SYNC_SLAVE;
	endfunction

	////////////////////////////////////////////////////////////////
	initial begin
		{nrst, read, write, go, rx_word_done, rx_ninth_in, rx_frame_err_in, rx_overrun_in, rx_buffer_read} = '0;
		{tsr_empty_in, tx_data_in, baud_clk_in, address, writedata, word, errors, checks, rises} = '0;
		tsr_empty_in = 1'b1;
		tx_data_in = 1'b1;
		void'($urandom(32'ha03574dd));
		tick(16);
		nrst <= 1'b1;
		tick(1);
		rd(RC, `RCV_SC_RESET);
		rd(TC, `XMT_SC_RESET | 8'h02);
		for (int i = 0; i < 12; i++) begin
			w = i < 4 ? rt[i] : 8'($urandom);
			v = i < 4 ? tt[i] : 8'($urandom);
			bus(1'b1, RC, w);
			bus(1'b1, TC, v);
			rd(RC, w & 8'hf0);
			rd(TC, tc_exp(v));
			chk({4'h0, config_mode, rx_nine, tx_nine}, {4'h0, cfg_exp(w, v), w[6], v[6]});
		end
		bus(1'b1, TC, 8'h00);
		bus(1'b1, RC, 8'h90);
		{rx_ninth_in, rx_frame_err_in} <= 2'h3;
		st(3'h4);
		rd(RC, 8'h91);
		st(3'h1);
		rd(RC, 8'h95);
		st(3'h2);
		rd(RC, 8'h97);
		bus(1'b1, RC, 8'h80);
		rd(RC, 8'h85);
		bus(1'b1, TC, 8'h90);
		bus(1'b1, RC, 8'ha0);
		chk({7'h0, rx_active}, 8'h01);
		{rx_ninth_in, rx_frame_err_in} <= 2'h0;
		st(3'h4);
		rd(RC, 8'h84);
		bus(1'b1, RC, 8'hb0);
		chk({6'h0, rx_active, tx_active}, 8'h02);
		bus(1'b1, TC, 8'h10);
		bus(1'b1, RC, 8'ha0);
		chk({7'h0, rx_active}, 8'h00);
		bus(1'b1, TC, 8'h30);
		bus(1'b1, RC, 8'h80);
		chk({6'h0, tx_active, data_pin_oe}, 8'h03);
		bus(1'b1, RC, 8'h90);
		chk({6'h0, tx_active, data_pin_oe}, 8'h00);
		bus(1'b1, TC, 8'h10);
		r0 = rises;
		word <= 8'($urandom);
		go <= 1'b1;
		tick(80);
		go <= 1'b0;
		chk(8'(rises - r0), 8'h08);
		bus(1'b1, IS, 8'hff);
		rd(IS, 8'h00);
		bus(1'b1, IM, 8'h04);
		st(3'h2);
		chk({7'h0, irq}, 8'h01);
		rd(IS, 8'h04);
		bus(1'b1, IM, 8'h00);
		chk({7'h0, irq}, 8'h00);
		bus(1'b1, IM, 8'h08);
		tsr_empty_in <= 1'b0;
		tick(2);
		rd(TC, 8'h10);
		tsr_empty_in <= 1'b1;
		tick(3);
		chk({7'h0, irq}, 8'h01);
		bus(1'b1, IS, 8'h0c);
		chk({7'h0, irq}, 8'h00);
		bus(1'b1, 8'h00, 8'hff);
		rd(8'h00, 8'h00);
		close_out;
	end
endmodule // tb

/* usart_ctl.v */
// control and status registers and pin direction logic of the serial port
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Function
// - async full duplex, sync master, sync slave
// - port enable claims both pins, else off
// - block drives both pin directions itself
// - clock source selects sync master or slave
// - separate nine-bit select per direction
// - ninth received bit readable in status
// - single receive takes one byte, self-clears
// - single receive ignored as sync slave
// - async continuous enable gates reception
// - sync continuous receive overrides single receive
// - framing flag refreshed on buffer read
// - overrun sticks until continuous enable cleared
// - unimplemented bits read as zero
`include "usart_ctl_defines.vh"

module usart_ctl (
	// clock and reset
	input  wire        clk_sys,
	input  wire        nrst,
	// avalon-mm slave
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output reg         waitrequest,
	// interrupt
	output reg         irq,
	// datapath status, same clock
	input  wire        rx_word_done,
	input  wire        rx_ninth_in,
	input  wire        rx_frame_err_in,
	input  wire        rx_overrun_in,
	input  wire        rx_buffer_read,
	input  wire        tsr_empty_in,
	input  wire        tx_data_in,
	input  wire        baud_clk_in,
	// datapath control
	output reg  [1:0]  config_mode,
	output reg         rx_active,
	output reg         tx_active,
	output reg         rx_nine,
	output reg         tx_nine,
	output reg         tx_ninth_bit,
	output reg         data_in,
	output reg         link_clk_rise,
	output reg         link_clk_fall,
	// receive_data_pin
	input  wire        data_pin_i,
	output reg         data_pin_o,
	output reg         data_pin_oe,
	// transmit_clock_pin
	input  wire        clk_pin_i,
	output reg         clk_pin_o,
	output reg         clk_pin_oe
);

////////////////////////////////////////////////////////////////////////////////
// register bits

reg        port_enable_r;
reg        receive_nine_bit_select_r;
reg        single_receive_enable_r;
reg        continuous_receive_enable_r;
reg        framing_error_flag_r;
reg        frame_err_pend_r;
reg        overrun_flag_r;
reg        receive_ninth_bit_r;
reg        clock_source_select_r;
reg        transmit_nine_bit_select_r;
reg        transmit_enable_r;
reg        sync_mode_r;
reg        shift_register_empty_r;
reg        transmit_ninth_bit_r;
reg [3:0]  irq_stat_r;
reg [3:0]  irq_mask_r;
reg        tsr_empty_d_r;

// pin synchronisers
reg        data_s1_r;
reg        data_s2_r;
reg        clk_s1_r;
reg        clk_s2_r;
reg        clk_s3_r;

function hit;
	input [7:0] addr;
	input [7:0] idx;
	begin
		hit = (addr == {idx[5:0], 2'b00});
	end
endfunction

localparam [7:0] RC_RST = `RCV_SC_RESET;

wire       acc    = (read | write) & ~waitrequest;
wire       wr     = write & ~waitrequest;
wire       wr_rc  = wr & hit(address, `RCV_SC_IDX);
wire       wr_tc  = wr & hit(address, `XMT_SC_IDX);
wire       wr_st  = wr & hit(address, `IRQ_STAT_IDX);
wire       wr_mk  = wr & hit(address, `IRQ_MASK_IDX);

////////////////////////////////////////////////////////////////////////////////
// configuration decode

reg  [1:0] cfg_nxt;
reg        rx_nxt;
reg        tx_nxt;
reg        single_eff;

always @* begin
	if (!port_enable_r)
		cfg_nxt = `CFG_OFF;
	else if (!sync_mode_r)
		cfg_nxt = `CFG_ASYNC;
	else if (clock_source_select_r)
		cfg_nxt = `CFG_SYNC_MASTER;
	else
		cfg_nxt = `CFG_SYNC_SLAVE;
	single_eff = (cfg_nxt == `CFG_SYNC_MASTER) & single_receive_enable_r;
	case (cfg_nxt)
		`CFG_ASYNC: begin
			rx_nxt = continuous_receive_enable_r;
			tx_nxt = transmit_enable_r;
		end
		`CFG_SYNC_MASTER, `CFG_SYNC_SLAVE: begin
			rx_nxt = continuous_receive_enable_r | single_eff;
			tx_nxt = transmit_enable_r & ~rx_nxt;
		end
		default: begin
			rx_nxt = 1'b0;
			tx_nxt = 1'b0;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// bus slave: one wait cycle, then answer

always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		waitrequest <= 1'b1;
		readdata    <= 32'h0000_0000;
	end else begin
		waitrequest <= ~((read | write) & waitrequest);
		if (read & waitrequest) begin
			if (hit(address, `RCV_SC_IDX))
				readdata <= {24'h00_0000, port_enable_r, receive_nine_bit_select_r,
					single_receive_enable_r, continuous_receive_enable_r, 1'b0,
					framing_error_flag_r, overrun_flag_r, receive_ninth_bit_r};
			else if (hit(address, `XMT_SC_IDX))
				readdata <= {24'h00_0000, clock_source_select_r, transmit_nine_bit_select_r,
					transmit_enable_r, sync_mode_r, 2'b00,
					shift_register_empty_r, transmit_ninth_bit_r};
			else if (hit(address, `IRQ_STAT_IDX))
				readdata <= {28'h000_0000, irq_stat_r};
			else if (hit(address, `IRQ_MASK_IDX))
				readdata <= {28'h000_0000, irq_mask_r};
			else
				readdata <= 32'h0000_0000;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control registers

always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		port_enable_r               <= RC_RST[`RC_PORT_EN];
		receive_nine_bit_select_r   <= 1'b0;
		single_receive_enable_r     <= 1'b0;
		continuous_receive_enable_r <= 1'b0;
		clock_source_select_r       <= 1'b0;
		transmit_nine_bit_select_r  <= 1'b0;
		transmit_enable_r           <= 1'b0;
		sync_mode_r                 <= 1'b0;
		transmit_ninth_bit_r        <= 1'b0;
		irq_mask_r                  <= `IRQ_RESET;
	end else begin
		if (wr_rc) begin
			port_enable_r               <= writedata[`RC_PORT_EN];
			receive_nine_bit_select_r   <= writedata[`RC_NINE_SEL];
			single_receive_enable_r     <= writedata[`RC_SINGLE_EN];
			continuous_receive_enable_r <= writedata[`RC_CONT_EN];
		end else if (rx_word_done & single_eff & ~continuous_receive_enable_r) begin
			single_receive_enable_r     <= 1'b0;
		end
		if (wr_tc) begin
			clock_source_select_r       <= writedata[`TC_CLK_SRC];
			transmit_nine_bit_select_r  <= writedata[`TC_NINE_SEL];
			transmit_enable_r           <= writedata[`TC_XMT_EN];
			sync_mode_r                 <= writedata[`TC_SYNC_MODE];
			transmit_ninth_bit_r        <= writedata[`TC_NINTH_BIT];
		end
		if (wr_mk)
			irq_mask_r <= writedata[3:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// status flags

wire cont_clr = wr_rc & ~writedata[`RC_CONT_EN];
wire [3:0] ev = {tsr_empty_in & ~tsr_empty_d_r, rx_overrun_in, rx_frame_err_in & rx_word_done, rx_word_done};

always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		framing_error_flag_r   <= 1'b0;
		frame_err_pend_r       <= 1'b0;
		overrun_flag_r         <= 1'b0;
		receive_ninth_bit_r    <= 1'b0;
		shift_register_empty_r <= 1'b1;
		tsr_empty_d_r          <= 1'b1;
		irq_stat_r             <= `IRQ_RESET;
	end else begin
		if (rx_word_done) begin
			frame_err_pend_r    <= rx_frame_err_in;
			receive_ninth_bit_r <= rx_ninth_in;
		end
		if (rx_buffer_read)
			framing_error_flag_r <= rx_word_done ? rx_frame_err_in : frame_err_pend_r;
		if (rx_overrun_in)
			overrun_flag_r <= 1'b1;
		else if (cont_clr)
			overrun_flag_r <= 1'b0;
		shift_register_empty_r <= tsr_empty_in;
		tsr_empty_d_r          <= tsr_empty_in;
		irq_stat_r <= ev | (irq_stat_r & ~(wr_st ? writedata[3:0] : 4'h0));
	end
end

////////////////////////////////////////////////////////////////////////////////
// link pin synchronisers and edge detect

always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		data_s1_r     <= 1'b1;
		data_s2_r     <= 1'b1;
		clk_s1_r      <= 1'b1;
		clk_s2_r      <= 1'b1;
		clk_s3_r      <= 1'b1;
		data_in       <= 1'b1;
		link_clk_rise <= 1'b0;
		link_clk_fall <= 1'b0;
	end else begin
		data_s1_r     <= data_pin_i;
		data_s2_r     <= data_s1_r;
		clk_s1_r      <= clk_pin_i;
		clk_s2_r      <= clk_s1_r;
		clk_s3_r      <= clk_s2_r;
		data_in       <= data_s2_r;
		link_clk_rise <= (config_mode == `CFG_SYNC_SLAVE) & clk_s2_r & ~clk_s3_r;
		link_clk_fall <= (config_mode == `CFG_SYNC_SLAVE) & ~clk_s2_r & clk_s3_r;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs to datapath and pins

always @(posedge clk_sys or negedge nrst) begin
	if (!nrst) begin
		config_mode  <= `CFG_OFF;
		rx_active    <= 1'b0;
		tx_active    <= 1'b0;
		rx_nine      <= 1'b0;
		tx_nine      <= 1'b0;
		tx_ninth_bit <= 1'b0;
		data_pin_o   <= 1'b1;
		data_pin_oe  <= 1'b0;
		clk_pin_o    <= 1'b1;
		clk_pin_oe   <= 1'b0;
		irq          <= 1'b0;
	end else begin
		config_mode  <= cfg_nxt;
		rx_active    <= rx_nxt;
		tx_active    <= tx_nxt;
		rx_nine      <= receive_nine_bit_select_r;
		tx_nine      <= transmit_nine_bit_select_r;
		tx_ninth_bit <= transmit_ninth_bit_r;
		irq          <= |(ev | (irq_stat_r & irq_mask_r)) & |((ev | irq_stat_r) & irq_mask_r);
		case (cfg_nxt)
			`CFG_ASYNC: begin
				data_pin_oe <= 1'b0;
				data_pin_o  <= 1'b1;
				clk_pin_oe  <= 1'b1;
				clk_pin_o   <= tx_nxt ? tx_data_in : 1'b1;
			end
			`CFG_SYNC_MASTER: begin
				data_pin_oe <= tx_nxt;
				data_pin_o  <= tx_data_in;
				clk_pin_oe  <= 1'b1;
				clk_pin_o   <= baud_clk_in;
			end
			`CFG_SYNC_SLAVE: begin
				data_pin_oe <= tx_nxt;
				data_pin_o  <= tx_data_in;
				clk_pin_oe  <= 1'b0;
				clk_pin_o   <= 1'b1;
			end
			default: begin
				data_pin_oe <= 1'b0;
				data_pin_o  <= 1'b1;
				clk_pin_oe  <= 1'b0;
				clk_pin_o   <= 1'b1;
			end
		endcase
	end
end

endmodule // usart_ctl

/* usart_ctl_asserts.sv */
// port-level checks of the serial control block
`timescale 1ns/1ns
`include "usart_ctl_defines.vh"

module usart_ctl_asserts (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// register bus
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	// datapath control and pins
	input wire logic [1:0]  config_mode,
	input wire logic        rx_active,
	input wire logic        tx_active,
	input wire logic        link_clk_rise,
	input wire logic        link_clk_fall,
	input wire logic        data_pin_oe,
	input wire logic        clk_pin_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");
	wait_pulse_a: assert property (!waitrequest |=> waitrequest)
		else $error("answer held too long");
	upper_zero_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
		else $error("upper read bits set");
	off_quiet_a: assert property (config_mode == `CFG_OFF && $past(config_mode) == `CFG_OFF |-> !data_pin_oe && !clk_pin_oe)
		else $error("pin driven while off");
	async_dir_a: assert property (config_mode == `CFG_ASYNC && $past(config_mode) == `CFG_ASYNC |-> clk_pin_oe && !data_pin_oe)
		else $error("async pin direction");
	master_clk_a: assert property (config_mode == `CFG_SYNC_MASTER && $past(config_mode) == `CFG_SYNC_MASTER |-> clk_pin_oe)
		else $error("master clock not driven");
	slave_clk_a: assert property (config_mode == `CFG_SYNC_SLAVE && $past(config_mode) == `CFG_SYNC_SLAVE |-> !clk_pin_oe)
		else $error("slave drives clock");
	rx_over_tx_a: assert property (config_mode[1] && rx_active |-> !tx_active)
		else $error("transmit during sync receive");
	edge_pulse_a: assert property (link_clk_rise |=> !link_clk_rise && !link_clk_fall)
		else $error("edge pulse too long");
	slave_edges_a: assert property (link_clk_rise || link_clk_fall |-> config_mode == `CFG_SYNC_SLAVE)
		else $error("edge outside slave mode");
endmodule // usart_ctl_asserts

bind usart_ctl usart_ctl_asserts i_chk (.*);

/* usart_ctl_defines.vh */
// register map, field positions, reset values and codes for the serial control block
`ifndef USART_CTL_DEFINES_VH
`define USART_CTL_DEFINES_VH

// register indices; byte address is four times the index
`define RCV_SC_IDX        8'h13
`define XMT_SC_IDX        8'h15
`define IRQ_STAT_IDX      8'h18
`define IRQ_MASK_IDX      8'h19

// receive_status_control fields
`define RC_PORT_EN        7
`define RC_NINE_SEL       6
`define RC_SINGLE_EN      5
`define RC_CONT_EN        4
`define RC_FRAME_ERR      2
`define RC_OVERRUN        1
`define RC_NINTH_BIT      0

// transmit_status_control fields
`define TC_CLK_SRC        7
`define TC_NINE_SEL       6
`define TC_XMT_EN         5
`define TC_SYNC_MODE      4
`define TC_SR_EMPTY       1
`define TC_NINTH_BIT      0

// interrupt status and mask fields
`define IRQ_RX_WORD       0
`define IRQ_FRAME         1
`define IRQ_OVERRUN       2
`define IRQ_TX_EMPTY      3
`define IRQ_WIDTH         4

// reset values
`define RCV_SC_RESET      8'h00
`define XMT_SC_RESET      8'h00
`define IRQ_RESET         4'h0

// operating configurations
`define CFG_OFF           2'h0
`define CFG_ASYNC         2'h1
`define CFG_SYNC_MASTER   2'h2
`define CFG_SYNC_SLAVE    2'h3

`endif
